// ==== logic/lmr_consts.svh ====
/*
 * Register offsets, field positions, reset values and serial frame
 * figures of the line monitor readout block.
 * Assumes it is included by its bare name from the package and modules.
 */
`ifndef LMR_CONSTS_SVH
`define LMR_CONSTS_SVH

// ****************************************************************
// Register offsets (7-bit serial address)
// ****************************************************************
`define LMR_ADDR_BATTERY_VOLTAGE_SENSE_A 7'h52
`define LMR_ADDR_BATTERY_VOLTAGE_SENSE_B 7'h53
`define LMR_ADDR_SWITCH_ONE_CURRENT      7'h54
`define LMR_ADDR_SWITCH_TWO_CURRENT      7'h55
`define LMR_ADDR_SWITCH_THREE_CURRENT    7'h56
`define LMR_ADDR_SWITCH_FOUR_CURRENT     7'h57
`define LMR_ADDR_SWITCH_FIVE_CURRENT     7'h58
`define LMR_ADDR_SWITCH_SIX_CURRENT      7'h59
`define LMR_ADDR_CONVERTER_PWM_PERIOD    7'h5C

// ****************************************************************
// Reset values and fields
// ****************************************************************
`define LMR_MEAS_RESET         8'h00
`define LMR_PERIOD_RESET       8'hFF
`define LMR_PERIOD_FIXED_BIT   6
`define LMR_PERIOD_WRITE_MASK  8'hBF
`define LMR_UNMAPPED_READ      8'h00

// ****************************************************************
// Serial frame: one control byte, one data byte, MSB first
// ****************************************************************
`define LMR_FRAME_BYTE_BITS    8
`define LMR_CTRL_READ_BIT      7

// ****************************************************************
// Converter timebase: one period step in picoseconds
// ****************************************************************
`define LMR_PERIOD_STEP_PS     61035

`endif

// ==== logic/lmr_pkg.sv ====
/*
 * Types shared by the line monitor readout block.
 * Assumes lmr_consts.svh is on the include path.
 */
`include "lmr_consts.svh"

package lmr_pkg;

    // Serial port frame phase
    typedef enum logic [1:0] {
        LMR_PH_IDLE = 2'b00,
        LMR_PH_CTRL = 2'b01,
        LMR_PH_DATA = 2'b10
    } lmr_phase_t;

    typedef logic [7:0] lmr_byte_t;
    typedef logic [6:0] lmr_addr_t;

endpackage : lmr_pkg

// ==== logic/lmr_serial_port.sv ====
/*
 * Serial control port slave: control byte (bit 7 = read, 6:0 address)
 * then one data byte, MSB first. Input sampled on rising serial clock,
 * output launched on falling serial clock.
 * Assumes serial clock below one quarter of clk_i; pins are asynchronous.
 */
`timescale 1ns/1ps

module lmr_serial_port
    import lmr_pkg::*;
(
    // Clock, reset, enable
    input  wire logic      clk_i,
    input  wire logic      rst_i,
    input  wire logic      ce_i,
    // Serial pins
    input  wire logic      sclk_i,
    input  wire logic      cs_n_i,
    input  wire logic      sdi_i,
    output logic           sdo_o,
    output logic           sdo_oe_o,
    // Register access
    output lmr_addr_t      addr_o,
    output logic           wr_o,
    output lmr_byte_t      wdata_o,
    input  wire lmr_byte_t rdata_i
);

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [1:0] sclk_sync_q;
    logic [1:0] cs_sync_q;
    logic [1:0] sdi_sync_q;
    logic       sclk_prev_q;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sclk_sync_q <= 2'b00;
            cs_sync_q   <= 2'b11;
            sdi_sync_q  <= 2'b00;
            sclk_prev_q <= 1'b0;
        end else if (ce_i) begin
            sclk_sync_q <= {sclk_sync_q[0], sclk_i};
            cs_sync_q   <= {cs_sync_q[0], cs_n_i};
            sdi_sync_q  <= {sdi_sync_q[0], sdi_i};
            sclk_prev_q <= sclk_sync_q[1];
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic selected;
    assign sclk_rise = sclk_sync_q[1] & ~sclk_prev_q;
    assign sclk_fall = ~sclk_sync_q[1] & sclk_prev_q;
    assign selected  = ~cs_sync_q[1];

    // ****************************************************************
    // Frame sequencer
    // ****************************************************************
    lmr_phase_t phase_q;
    logic [2:0] bit_cnt_q;
    lmr_byte_t  shift_q;
    logic       read_q;
    lmr_byte_t  tx_q;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            phase_q   <= LMR_PH_IDLE;
            bit_cnt_q <= 3'h0;
            shift_q   <= 8'h00;
            read_q    <= 1'b0;
            addr_o    <= 7'h00;
            wr_o      <= 1'b0;
            wdata_o   <= 8'h00;
        end else if (ce_i) begin
            wr_o <= 1'b0;
            case (phase_q)
                LMR_PH_IDLE: begin
                    bit_cnt_q <= 3'h0;
                    if (selected) begin
                        phase_q <= LMR_PH_CTRL;
                    end
                end
                LMR_PH_CTRL, LMR_PH_DATA: begin
                    if (!selected) begin
                        // Short frames are dropped without a write
                        phase_q <= LMR_PH_IDLE;
                    end else if (sclk_rise) begin
                        shift_q   <= {shift_q[6:0], sdi_sync_q[1]};
                        bit_cnt_q <= bit_cnt_q + 3'h1;
                        if (bit_cnt_q == 3'h7) begin
                            if (phase_q == LMR_PH_CTRL) begin
                                read_q  <= shift_q[`LMR_CTRL_READ_BIT - 1];
                                addr_o  <= {shift_q[5:0], sdi_sync_q[1]};
                                phase_q <= LMR_PH_DATA;
                            end else begin
                                wdata_o <= {shift_q[6:0], sdi_sync_q[1]};
                                wr_o    <= ~read_q;
                                phase_q <= LMR_PH_IDLE;
                            end
                        end
                    end
                end
                default: begin
                    phase_q <= LMR_PH_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Read data launch
    // ****************************************************************
    logic data_first;
    assign data_first = (phase_q == LMR_PH_DATA) && (bit_cnt_q == 3'h0);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_q     <= 8'h00;
            sdo_o    <= 1'b0;
            sdo_oe_o <= 1'b0;
        end else if (ce_i) begin
            sdo_oe_o <= selected && (phase_q == LMR_PH_DATA) && read_q;
            if (sclk_fall && (phase_q == LMR_PH_DATA)) begin
                if (data_first) begin
                    // Register contents are fetched only now, after the address settled
                    sdo_o <= rdata_i[7];
                    tx_q  <= {rdata_i[6:0], 1'b0};
                end else begin
                    sdo_o <= tx_q[7];
                    tx_q  <= {tx_q[6:0], 1'b0};
                end
            end
        end
    end

endmodule // lmr_serial_port

// ==== logic/lmr_readout.sv ====
/*
 * Line monitor readout: battery voltage and six switch current sense
 * registers, and the converter PWM period register with its period timer.
 * Only the period register takes writes; the sense registers hold the
 * codes captured at the last sample strobe.
 * Assumes software picks a period code that suits the switch type.
 * Assumes measurement codes and the 61.035 ns timebase tick come from
 * logic on clk_i; serial pins arrive from outside and are synchronised.
 */
// Contract
// - Two read-only battery voltage registers report live battery code, 0.376 V steps; both return the code captured at the last sample strobe.
// - Switch one and two currents report live code, 0.319 mA steps; both return the code captured at the last sample strobe.
// - With extended feed enabled, switch one/two exclude extended offset current.
// - Switch three and four currents report live code, 37.6 uA steps; both return the code captured at the last sample strobe.
// - Switch five and six currents report live code, 0.316 mA steps; both return the code captured at the last sample strobe.
// - Period code sets PWM period at 61.035 ns per code step.
// - Period bit 6 always reads one; writes only reach bits 7, 5:0.
`timescale 1ns/1ps
`include "lmr_consts.svh"

module lmr_readout
    import lmr_pkg::*;
#(
    parameter int unsigned CODE_W = 8
)
(
    // Clock, reset, enable
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              ce_i,
    // Serial control pins
    input  wire logic              sclk_i,
    input  wire logic              cs_n_i,
    input  wire logic              sdi_i,
    output logic                   sdo_o,
    output logic                   sdo_oe_o,
    // Measurement codes from the converter front end
    input  wire logic              sample_i,
    input  wire logic [CODE_W-1:0] battery_voltage_i,
    input  wire logic [CODE_W-1:0] switch_one_raw_i,
    input  wire logic [CODE_W-1:0] switch_two_raw_i,
    input  wire logic [CODE_W-1:0] switch_three_i,
    input  wire logic [CODE_W-1:0] switch_four_i,
    input  wire logic [CODE_W-1:0] switch_five_i,
    input  wire logic [CODE_W-1:0] switch_six_i,
    input  wire logic [CODE_W-1:0] extended_offset_current_i,
    input  wire logic              extended_battery_feed_enable_i,
    // Converter timebase and period output
    input  wire logic              step_tick_i,
    output logic [CODE_W-1:0]      converter_period_code_o,
    output logic                   period_start_o
);

    // ****************************************************************
    // Serial port
    // ****************************************************************
    lmr_addr_t acc_addr;
    logic      acc_wr;
    lmr_byte_t acc_wdata;
    lmr_byte_t acc_rdata;

    lmr_serial_port u_serial (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .ce_i     (ce_i),
        .sclk_i   (sclk_i),
        .cs_n_i   (cs_n_i),
        .sdi_i    (sdi_i),
        .sdo_o    (sdo_o),
        .sdo_oe_o (sdo_oe_o),
        .addr_o   (acc_addr),
        .wr_o     (acc_wr),
        .wdata_o  (acc_wdata),
        .rdata_i  (acc_rdata)
    );

    // ****************************************************************
    // Measurement capture
    // ****************************************************************
    localparam int unsigned NUM_MEAS = 7;

    // Index order: battery, then switches one to six
    logic [CODE_W-1:0] meas_in  [NUM_MEAS];
    logic [CODE_W-1:0] meas_q   [NUM_MEAS];
    logic [CODE_W-1:0] switch_one_net;
    logic [CODE_W-1:0] switch_two_net;

    // Saturating removal of the extended offset share
    function automatic logic [CODE_W-1:0] lmr_strip_offset(
        input logic [CODE_W-1:0] raw,
        input logic [CODE_W-1:0] offset,
        input logic              enable
    );
        logic [CODE_W-1:0] result;
        result = raw;
        if (enable) begin
            result = (raw > offset) ? CODE_W'(raw - offset) : '0;
        end
        return result;
    endfunction

    assign switch_one_net = lmr_strip_offset(switch_one_raw_i, extended_offset_current_i,
                                             extended_battery_feed_enable_i);
    assign switch_two_net = lmr_strip_offset(switch_two_raw_i, extended_offset_current_i,
                                             extended_battery_feed_enable_i);

    assign meas_in[0] = battery_voltage_i;
    assign meas_in[1] = switch_one_net;
    assign meas_in[2] = switch_two_net;
    assign meas_in[3] = switch_three_i;
    assign meas_in[4] = switch_four_i;
    assign meas_in[5] = switch_five_i;
    assign meas_in[6] = switch_six_i;

    // Writes never reach these; only the sample strobe loads them
    for (genvar g = 0; g < NUM_MEAS; g++) begin : g_meas
        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                meas_q[g] <= `LMR_MEAS_RESET;
            end else if (ce_i && sample_i) begin
                meas_q[g] <= meas_in[g];
            end
        end
    end

    // ****************************************************************
    // Write decode
    // ****************************************************************
    // Only the period register takes writes; sense addresses fall through
    function automatic logic lmr_is_period(input lmr_addr_t addr);
        logic hit;
        hit = 1'b0;
        if (addr == `LMR_ADDR_CONVERTER_PWM_PERIOD) begin
            hit = 1'b1;
        end
        return hit;
    endfunction

    logic period_wr;
    assign period_wr = ce_i && acc_wr && lmr_is_period(acc_addr);

    // ****************************************************************
    // Converter period register
    // ****************************************************************
    logic [CODE_W-1:0] period_code_q;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            period_code_q <= `LMR_PERIOD_RESET;
        end else if (period_wr) begin
            period_code_q <= (acc_wdata & `LMR_PERIOD_WRITE_MASK)
                           | ~`LMR_PERIOD_WRITE_MASK;
        end
    end

    // ****************************************************************
    // Read decode
    // ****************************************************************
    always_comb begin
        if (acc_addr == `LMR_ADDR_BATTERY_VOLTAGE_SENSE_A) begin
            acc_rdata = meas_q[0];
        end else if (acc_addr == `LMR_ADDR_BATTERY_VOLTAGE_SENSE_B) begin
            acc_rdata = meas_q[0];
        end else if (acc_addr == `LMR_ADDR_SWITCH_ONE_CURRENT) begin
            acc_rdata = meas_q[1];
        end else if (acc_addr == `LMR_ADDR_SWITCH_TWO_CURRENT) begin
            acc_rdata = meas_q[2];
        end else if (acc_addr == `LMR_ADDR_SWITCH_THREE_CURRENT) begin
            acc_rdata = meas_q[3];
        end else if (acc_addr == `LMR_ADDR_SWITCH_FOUR_CURRENT) begin
            acc_rdata = meas_q[4];
        end else if (acc_addr == `LMR_ADDR_SWITCH_FIVE_CURRENT) begin
            acc_rdata = meas_q[5];
        end else if (acc_addr == `LMR_ADDR_SWITCH_SIX_CURRENT) begin
            acc_rdata = meas_q[6];
        end else if (lmr_is_period(acc_addr)) begin
            acc_rdata = period_code_q | ~`LMR_PERIOD_WRITE_MASK;
        end else begin
            acc_rdata = `LMR_UNMAPPED_READ;
        end
    end

    // ****************************************************************
    // PWM period timer
    // ****************************************************************
    // The timebase tick is one 61.035 ns step; 40 MHz cannot resolve it,
    // so the step is supplied as a strobe. A new code takes effect at the
    // next period boundary to avoid a truncated cycle. Software keeps the
    // code inside the range that suits the switch type.
    logic [CODE_W-1:0] step_cnt_q;
    logic [CODE_W-1:0] active_code_q;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            step_cnt_q     <= '0;
            active_code_q  <= `LMR_PERIOD_RESET;
            period_start_o <= 1'b0;
        end else if (ce_i) begin
            period_start_o <= 1'b0;
            if (step_tick_i) begin
                if (step_cnt_q >= CODE_W'(active_code_q - 8'h01)) begin
                    step_cnt_q     <= '0;
                    active_code_q  <= period_code_q;
                    period_start_o <= 1'b1;
                end else begin
                    step_cnt_q <= step_cnt_q + 8'h01;
                end
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            converter_period_code_o <= `LMR_PERIOD_RESET;
        end else if (ce_i) begin
            converter_period_code_o <= active_code_q;
        end
    end

endmodule // lmr_readout

// ==== verification/lmr_readout_properties.sv ====
/*
 * Concurrent checks on the readout block's serial and period ports.
 * Assumes it is bound into lmr_readout and sees only its ports.
 */
`timescale 1ns/1ps

module lmr_readout_properties
    import lmr_pkg::*;
#(
    parameter int unsigned CODE_W = 8
)
(
    // Clock, reset
    input wire logic              clk_i,
    input wire logic              rst_i,
    // Serial pins
    input wire logic              sclk_i,
    input wire logic              cs_n_i,
    input wire logic              sdo_o,
    input wire logic              sdo_oe_o,
    // Converter timebase
    input wire logic              step_tick_i,
    input wire logic [CODE_W-1:0] converter_period_code_o,
    input wire logic              period_start_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // ****************************
    // Helper counters
    // ****************************
    logic              sclk_q;
    logic [4:0]        rise_q;
    logic [8:0]        tick_q;
    logic [CODE_W-1:0] code_q;
    logic              seen_q;
    logic              start_q;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sclk_q <= 1'b0;
            rise_q <= 5'h00;
        end else begin
            sclk_q <= sclk_i;
            if (cs_n_i)
                rise_q <= 5'h00;
            else if (sclk_i && !sclk_q)
                rise_q <= rise_q + 5'h01;
        end
    end

    // First period after reset is skipped: its start was never seen.
    // Code output trails the boundary by one cycle, so it is taken one later.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tick_q  <= 9'h000;
            code_q  <= '1;
            seen_q  <= 1'b0;
            start_q <= 1'b0;
        end else begin
            start_q <= period_start_o;
            if (start_q) begin
                code_q <= converter_period_code_o;
            end
            if (period_start_o) begin
                // A tick in the start cycle already belongs to the new period
                tick_q <= {8'h00, step_tick_i};
                seen_q <= 1'b1;
            end else if (step_tick_i) begin
                tick_q <= tick_q + 9'h001;
            end
        end
    end

    // ****************************
    // Properties
    // ****************************
    sequence deselect_s;
        cs_n_i [*6];
    endsequence

    sequence high_phase_s;
        (sdo_oe_o && sclk_i) [*2];
    endsequence

    period_reset_a: assert property ($fell(rst_i) |-> converter_period_code_o == 8'hFF)
        else $error("period code not at reset value");
    fixed_bit_a: assert property (converter_period_code_o[6])
        else $error("period code bit 6 low");
    start_pulse_a: assert property (period_start_o |=> !period_start_o)
        else $error("period start longer than one cycle");
    start_tick_a: assert property (period_start_o |-> $past(step_tick_i))
        else $error("period start without a step tick");
    period_len_a: assert property (period_start_o && seen_q |-> tick_q == {1'b0, code_q})
        else $error("period length differs from code");
    oe_ctrl_a: assert property ($rose(sdo_oe_o) |-> rise_q == 5'h08)
        else $error("data out enabled before control byte done");
    oe_release_a: assert property (deselect_s |-> !sdo_oe_o)
        else $error("data out still enabled when deselected");
    sdo_hold_a: assert property (high_phase_s |-> $stable(sdo_o))
        else $error("data out moved while serial clock high");

endmodule // lmr_readout_properties

bind lmr_readout lmr_readout_properties #(.CODE_W(CODE_W)) i_lmr_readout_properties (
    .clk_i, .rst_i, .sclk_i, .cs_n_i, .sdo_o, .sdo_oe_o,
    .step_tick_i, .converter_period_code_o, .period_start_o
);

// ==== verification/lmr_host_model.sv ====
/*
 * Host-side serial master model for the line monitor readout block.
 * Assumes the bench calls its frame task only after reset release.
 */
`timescale 1ns/1ps

module lmr_host_model (
    // Clock
    input  wire logic clk_i,
    // Serial pins
    input  wire logic sdo_i,
    input  wire logic sdo_oe_i,
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      sdi_o
);
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        sdi_o  = 1'b0;
    end

    // Eight system clocks per serial phase, well above the port minimum
    task automatic frame(input logic [7:0] ctl, input logic [7:0] wd, output logic [7:0] rd);
        logic [15:0] sh;
        sh = {ctl, wd};
        rd = 8'h00;
        @(negedge clk_i) cs_n_o <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            sdi_o <= sh[i];
            repeat (8) @(negedge clk_i);
            if (i < 8)
                rd[i] = sdo_oe_i ? sdo_i : 1'bx;
            sclk_o <= 1'b1;
            repeat (8) @(negedge clk_i);
            sclk_o <= 1'b0;
        end
        repeat (8) @(negedge clk_i);
        cs_n_o <= 1'b1;
        // Released line must not look like a held bit
        sdi_o  <= ~sh[0];
        repeat (8) @(negedge clk_i);
    endtask

    // Lower range for field-effect, upper for bipolar switches
    function automatic logic [7:0] period_code(input logic bjt, input logic [5:0] step);
        return {bjt, 1'b1, step};
    endfunction

endmodule // lmr_host_model

// ==== verification/lmr_readout_tb_top.sv ====
/*
 * Self-checking bench for lmr_readout: serial reads and writes,
 * measurement sampling, offset removal and the converter period.
 * Assumes lmr_host_model drives the serial pins; the checker is bound.
 */
`timescale 1ns/1ps
`include "lmr_consts.svh"

module lmr_readout_tb_top;
    import lmr_pkg::*;

    logic      clk_i = 1'b0;
    logic      rst_i = 1'b1;
    logic      sclk;
    logic      cs_n;
    logic      sdi;
    logic      sdo;
    logic      sdo_oe;
    logic      sample = 1'b0;
    logic      fe = 1'b0;
    logic      tick = 1'b0;
    logic      start;
    lmr_byte_t m [7];
    lmr_byte_t off = 8'h10;
    lmr_byte_t code;
    lmr_byte_t rd;
    int        n_fail = 0;
    int        cmp_count = 0;

    lmr_readout i_lmr_readout (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
        .sclk_i(sclk), .cs_n_i(cs_n), .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe),
        .sample_i(sample), .battery_voltage_i(m[0]),
        .switch_one_raw_i(m[1]), .switch_two_raw_i(m[2]),
        .switch_three_i(m[3]), .switch_four_i(m[4]),
        .switch_five_i(m[5]), .switch_six_i(m[6]),
        .extended_offset_current_i(off), .extended_battery_feed_enable_i(fe),
        .step_tick_i(tick), .converter_period_code_o(code), .period_start_o(start)
    );

    lmr_host_model i_lmr_host_model (
        .clk_i(clk_i), .sdo_i(sdo), .sdo_oe_i(sdo_oe),
        .sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi)
    );

    initial forever #12.5 clk_i = ~clk_i;

    // One timebase step every second clock
    always @(negedge clk_i) tick <= ~tick;

    // ****************************
    // Access and compare tasks
    // ****************************
    task automatic chk(input lmr_byte_t got, input lmr_byte_t exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd_chk(input lmr_addr_t a, input lmr_byte_t exp);
        i_lmr_host_model.frame({1'b1, a}, 8'h00, rd);
        chk(rd, exp);
    endtask

    task automatic wr(input lmr_addr_t a, input lmr_byte_t d);
        i_lmr_host_model.frame({1'b0, a}, d, rd);
    endtask

    // Expected code at address 0x52 + i; both battery places share m[0]
    function automatic lmr_byte_t meas(input int i);
        lmr_byte_t v;
        v = m[i == 0 ? 0 : i - 1];
        if (fe && (i == 2 || i == 3))
            v = (v > off) ? v - off : 8'h00;
        return v;
    endfunction

    task automatic all_meas;
        for (int i = 0; i < 8; i++)
            rd_chk(`LMR_ADDR_BATTERY_VOLTAGE_SENSE_A + lmr_addr_t'(i), meas(i));
    endtask

    task automatic pulse;
        @(negedge clk_i) sample <= 1'b1;
        @(negedge clk_i) sample <= 1'b0;
    endtask

    // Code in use is checked after a whole period has run on it
    task automatic wait_start(input lmr_byte_t exp);
        int k;
        repeat (2) begin
            k = 0;
            @(negedge clk_i);
            while (start !== 1'b1 && k < 600) begin
                @(negedge clk_i);
                k++;
            end
        end
        chk({7'h00, start}, 8'h01);
        chk(code, exp);
    endtask

    task automatic results;
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ****************************
    // Test sequence
    // ****************************
    initial begin
        for (int i = 0; i < 7; i++)
            m[i] = 8'h11 * (i + 1);
        repeat (6) @(negedge clk_i);
        rst_i = 1'b0;
        repeat (3) @(negedge clk_i);
        for (int i = 0; i < 8; i++)
            rd_chk(`LMR_ADDR_BATTERY_VOLTAGE_SENSE_A + lmr_addr_t'(i), 8'h00);
        rd_chk(`LMR_ADDR_CONVERTER_PWM_PERIOD, 8'hFF);
        rd_chk(7'h5A, `LMR_UNMAPPED_READ);
        m[0] = 8'hFF;
        m[1] = 8'h00;
        pulse();
        for (int i = 0; i < 8; i++)
            wr(`LMR_ADDR_BATTERY_VOLTAGE_SENSE_A + lmr_addr_t'(i), 8'hA5);
        all_meas();
        // Live inputs move without a sample: old code must stay
        fe = 1'b1;
        m[1] = 8'h50;
        m[2] = 8'h05;
        rd_chk(`LMR_ADDR_SWITCH_ONE_CURRENT, 8'h00);
        pulse();
        all_meas();
        wr(`LMR_ADDR_CONVERTER_PWM_PERIOD, i_lmr_host_model.period_code(1'b0, 6'h00));
        rd_chk(`LMR_ADDR_CONVERTER_PWM_PERIOD, 8'h40);
        wait_start(8'h40);
        wr(`LMR_ADDR_CONVERTER_PWM_PERIOD, 8'h80);
        rd_chk(`LMR_ADDR_CONVERTER_PWM_PERIOD, 8'hC0);
        wait_start(8'hC0);
        wr(`LMR_ADDR_CONVERTER_PWM_PERIOD, i_lmr_host_model.period_code(1'b1, 6'h3F));
        rd_chk(`LMR_ADDR_CONVERTER_PWM_PERIOD, 8'hFF);
        wait_start(8'hFF);
        results();
    end

    // Watchdog: the sequence needs about 13000 clocks
    initial begin
        repeat (20000) @(posedge clk_i);
        n_fail++;
        results();
    end

endmodule // lmr_readout_tb_top
